/* hw/pwmps_defines.vh */
/*
 Constants for the pwm pairing and clock-scaling slice: register word indices,
 field positions and a control mask. Assumes an APB slave with 32-bit words.
*/
// Operation
// - Three pairing bits join adjacent channel pairs
// - Cleared pairing bit keeps channels independent
// - Pair 4/5: 4 high, 5 low, ch5 controls
// - Pair 2/3: 2 high, 3 low, ch3 controls
// - Pair 0/1: 0 high, 1 low, ch1 controls
// - Wait-halt bit stops prescaler in wait
// - Freeze-halt bit stops prescaler in freeze
// - Registers usable in freeze; clock resumes
// - Test registers read zero, ignore writes
// - Scaled A is A over twice scale
// - Scale A zero means 256
// - Scale A write reloads its counter
// - Scaled B is B over twice scale
// - Scale B zero means 256
// - Scale B write reloads its counter
// - Clocks A, B are bus/2^n, n 0..7
// - Clock-select picks prescaled or scaled clock
`ifndef PWMPS_DEFINES_VH
`define PWMPS_DEFINES_VH
`define PWMPS_IDX_PRESCALE 8'h03
`define PWMPS_IDX_CHAN_CTL 8'h04
`define PWMPS_IDX_CTL 8'h05
`define PWMPS_IDX_TEST1 8'h06
`define PWMPS_IDX_TEST2 8'h07
`define PWMPS_IDX_SCLA 8'h08
`define PWMPS_IDX_SCLB 8'h09
`define PWMPS_BIT_J45 6
`define PWMPS_BIT_J23 5
`define PWMPS_BIT_J01 4
`define PWMPS_BIT_WAIT 3
`define PWMPS_BIT_FRZ 2
`define PWMPS_CTL_MASK 8'h7c
`define PWMPS_PRE_A_LSB 0
`define PWMPS_PRE_B_LSB 4
`define PWMPS_CC_SEL_LSB 0
`define PWMPS_CC_POL_LSB 8
`define PWMPS_CC_ALN_LSB 16
`define PWMPS_CC_EN_LSB 24
`endif

/* hw/pwmps_scaler.v */
/*
 Scale counter: divides ticks of a prescaled clock by twice the scale.
 Assumes src_tick is a one-cycle pulse on pclk.
*/
`timescale 1ns/1ns
module pwmps_scaler #(
   parameter W = 8
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Control
   input wire [W-1:0] scale,
   input wire reload,
   input wire src_tick,
   // Result
   output reg scaled_tick,
   output reg half_q
);
   reg [W:0] cnt_q;
   wire [W:0] start;
   // Zero stands for full scale
   assign start = (scale == {W{1'b0}}) ? {1'b1, {W{1'b0}}} : {1'b0, scale};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= {1'b1, {W{1'b0}}};
         half_q <= 1'b0;
         scaled_tick <= 1'b0;
      end else begin
         scaled_tick <= 1'b0;
         if (reload) begin
            cnt_q <= start;
         end else if (src_tick) begin
            if (cnt_q <= {{W{1'b0}}, 1'b1}) begin
               cnt_q <= start;
               half_q <= ~half_q;
               scaled_tick <= half_q;
            end else begin
               cnt_q <= cnt_q - {{W{1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // pwmps_scaler

/* hw/pwmps_top.v */
/*
 Pairing, low-power gating and clock scaling slice of a six-channel pwm,
 with its APB register file. Assumes wait and freeze arrive as pins, and
 that the channel counters outside use the per-channel ticks and the
 effective per-channel controls driven here.
*/
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "pwmps_defines.vh"
module pwmps_top (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Processor modes
   input wire wait_mode,
   input wire freeze_mode,
   // Raw channel outputs from the 8-bit and 16-bit modulators
   input wire [5:0] chan_wave,
   input wire [2:0] pair_wave,
   // Channel clocking and effective controls
   output reg [5:0] chan_tick_q,
   output reg [5:0] chan_enable_q,
   output reg [5:0] chan_polarity_q,
   output reg [5:0] chan_align_q,
   output reg [2:0] pair_active_q,
   output reg [5:0] modulator_output_port,
   output reg scaled_clock_a,
   output reg scaled_clock_b
);
   reg [7:0] pairing_and_low_power_control;
   reg [7:0] scale_a_divisor;
   reg [7:0] scale_b_divisor;
   reg [7:0] prescale_q;
   reg [31:0] chan_ctl_q;
   reg wait_s1_q, wait_s2_q, frz_s1_q, frz_s2_q;
   reg [6:0] pre_cnt_q;
   wire [7:0] pre_tick;
   wire [9:0] idx;
   wire aligned;
   wire wr_en;
   wire rd_en;
   wire halt;
   wire tick_a;
   wire tick_b;
   wire stick_a;
   wire stick_b;
   wire half_a;
   wire half_b;
   wire [2:0] pre_a;
   wire [2:0] pre_b;
   wire [5:0] sel;
   wire [5:0] en_raw;
   wire [5:0] pol_raw;
   wire [5:0] aln_raw;
   wire [2:0] join_bits;
   wire wr_scla;
   wire wr_sclb;
   wire [7:0] scale_a_in;
   wire [7:0] scale_b_in;
   reg [31:0] rd_d;
   reg err_d;
   reg [5:0] tick_d;

   assign idx = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign pre_a = prescale_q[`PWMPS_PRE_A_LSB +: 3];
   assign pre_b = prescale_q[`PWMPS_PRE_B_LSB +: 3];
   assign sel = chan_ctl_q[`PWMPS_CC_SEL_LSB +: 6];
   assign pol_raw = chan_ctl_q[`PWMPS_CC_POL_LSB +: 6];
   assign aln_raw = chan_ctl_q[`PWMPS_CC_ALN_LSB +: 6];
   assign en_raw = chan_ctl_q[`PWMPS_CC_EN_LSB +: 6];
   assign join_bits = {pairing_and_low_power_control[`PWMPS_BIT_J45],
                       pairing_and_low_power_control[`PWMPS_BIT_J23],
                       pairing_and_low_power_control[`PWMPS_BIT_J01]};
   assign wr_scla = wr_en & aligned & (idx == `PWMPS_IDX_SCLA);
   assign wr_sclb = wr_en & aligned & (idx == `PWMPS_IDX_SCLB);
   // The divisor register updates on the same edge, so the reload takes the bus value
   assign scale_a_in = wr_scla ? pwdata[7:0] : scale_a_divisor;
   assign scale_b_in = wr_sclb ? pwdata[7:0] : scale_b_divisor;

   // Mode pins come from another domain
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_s1_q <= 1'b0;
         wait_s2_q <= 1'b0;
         frz_s1_q <= 1'b0;
         frz_s2_q <= 1'b0;
      end else begin
         wait_s1_q <= wait_mode;
         wait_s2_q <= wait_s1_q;
         frz_s1_q <= freeze_mode;
         frz_s2_q <= frz_s1_q;
      end
   end

   // Gating the prescaler input halts every counter downstream at once
   assign halt = (wait_s2_q & pairing_and_low_power_control[`PWMPS_BIT_WAIT])
               | (frz_s2_q & pairing_and_low_power_control[`PWMPS_BIT_FRZ]);

   // Prescaler: pre_tick[n] pulses once per 2^n bus clocks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_q <= 7'h00;
      end else if (!halt) begin
         pre_cnt_q <= pre_cnt_q + 7'h01;
      end
   end

   assign pre_tick[0] = ~halt;
   genvar t;
   generate
      for (t = 1; t < 8; t = t + 1) begin : g_pre
         assign pre_tick[t] = ~halt & (&pre_cnt_q[t-1:0]);
      end
   endgenerate

   assign tick_a = pre_tick[pre_a];
   assign tick_b = pre_tick[pre_b];

   pwmps_scaler #(
      .W(8)
   ) u_scale_a (
      .pclk(pclk),
      .presetn(presetn),
      .scale(scale_a_in),
      .reload(wr_scla),
      .src_tick(tick_a),
      .scaled_tick(stick_a),
      .half_q(half_a)
   );

   pwmps_scaler #(
      .W(8)
   ) u_scale_b (
      .pclk(pclk),
      .presetn(presetn),
      .scale(scale_b_in),
      .reload(wr_sclb),
      .src_tick(tick_b),
      .scaled_tick(stick_b),
      .half_q(half_b)
   );

   // Channel clock choice; channels 2 and 3 use clock B
   always @* begin
      tick_d[0] = sel[0] ? stick_a : tick_a;
      tick_d[1] = sel[1] ? stick_a : tick_a;
      tick_d[2] = sel[2] ? stick_b : tick_b;
      tick_d[3] = sel[3] ? stick_b : tick_b;
      tick_d[4] = sel[4] ? stick_a : tick_a;
      tick_d[5] = sel[5] ? stick_a : tick_a;
   end

   // Per pair: low channel n+1 rules the joined channel; high channel idles
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_pair
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chan_tick_q[2*g+1:2*g] <= 2'b00;
               chan_enable_q[2*g+1:2*g] <= 2'b00;
               chan_polarity_q[2*g+1:2*g] <= 2'b00;
               chan_align_q[2*g+1:2*g] <= 2'b00;
               modulator_output_port[2*g+1:2*g] <= 2'b00;
               pair_active_q[g] <= 1'b0;
            end else if (join_bits[g]) begin
               // High byte counter shares the low channel's clock and controls
               chan_tick_q[2*g+1:2*g] <= {2{tick_d[2*g+1]}};
               chan_enable_q[2*g+1:2*g] <= {2{en_raw[2*g+1]}};
               chan_polarity_q[2*g+1:2*g] <= {2{pol_raw[2*g+1]}};
               chan_align_q[2*g+1:2*g] <= {2{aln_raw[2*g+1]}};
               modulator_output_port[2*g+1] <= pair_wave[g] & en_raw[2*g+1];
               modulator_output_port[2*g] <= 1'b0;
               pair_active_q[g] <= 1'b1;
            end else begin
               chan_tick_q[2*g+1:2*g] <= tick_d[2*g+1:2*g];
               chan_enable_q[2*g+1:2*g] <= en_raw[2*g+1:2*g];
               chan_polarity_q[2*g+1:2*g] <= pol_raw[2*g+1:2*g];
               chan_align_q[2*g+1:2*g] <= aln_raw[2*g+1:2*g];
               modulator_output_port[2*g+1:2*g] <= chan_wave[2*g+1:2*g] & en_raw[2*g+1:2*g];
               pair_active_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Scaled clock levels for observation
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scaled_clock_a <= 1'b0;
         scaled_clock_b <= 1'b0;
      end else begin
         scaled_clock_a <= half_a;
         scaled_clock_b <= half_b;
      end
   end

   // Register writes; pairing changes are not blocked while channels run
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pairing_and_low_power_control <= 8'h00;
         scale_a_divisor <= 8'h00;
         scale_b_divisor <= 8'h00;
         prescale_q <= 8'h00;
         chan_ctl_q <= 32'h0000_0000;
      end else if (wr_en & aligned) begin
         case (idx)
            `PWMPS_IDX_PRESCALE: prescale_q <= pwdata[7:0] & 8'h77;
            `PWMPS_IDX_CHAN_CTL: chan_ctl_q <= pwdata & 32'h3f3f_3f3f;
            `PWMPS_IDX_CTL: pairing_and_low_power_control <= pwdata[7:0] & `PWMPS_CTL_MASK;
            `PWMPS_IDX_SCLA: scale_a_divisor <= pwdata[7:0];
            `PWMPS_IDX_SCLB: scale_b_divisor <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read mux; test words are zero and writes to them are dropped
   always @* begin
      rd_d = 32'h0000_0000;
      err_d = ~aligned;
      case (idx)
         `PWMPS_IDX_PRESCALE: rd_d = {24'h00_0000, prescale_q};
         `PWMPS_IDX_CHAN_CTL: rd_d = chan_ctl_q;
         `PWMPS_IDX_CTL: rd_d = {24'h00_0000, pairing_and_low_power_control};
         `PWMPS_IDX_TEST1: rd_d = 32'h0000_0000;
         `PWMPS_IDX_TEST2: rd_d = 32'h0000_0000;
         `PWMPS_IDX_SCLA: rd_d = {24'h00_0000, scale_a_divisor};
         `PWMPS_IDX_SCLB: rd_d = {24'h00_0000, scale_b_divisor};
         default: err_d = 1'b1;
      endcase
   end

   // Zero-wait answer: pready and data registered during setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & err_d;
         // A refused read returns zero, even when the index itself is mapped
         prdata <= (psel & ~penable & ~pwrite & ~err_d) ? rd_d : 32'h0000_0000;
      end
   end

   wire unused_rd;
   assign unused_rd = rd_en;
endmodule // pwmps_top

/* test/pwmps_top_asserts.sv */
/* Port checker for pwmps_top: APB timing, reserved words, pairing and
   scaled clocks. Assumes the single pclk domain and the bind below. */
`timescale 1ns/1ns
module pwmps_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Channel side
   input wire logic [2:0] pair_active_q,
   input wire logic [5:0] chan_enable_q,
   input wire logic [5:0] chan_polarity_q,
   input wire logic [5:0] modulator_output_port,
   input wire logic scaled_clock_a
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no answer after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("pready held");
   property p_acc; pready |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("pready outside access");
   property p_rd0; !pready |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("stray read data");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without pready");
   property p_una; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
   a_una: assert property (p_una) else $error("unaligned accepted");
   property p_tst; pready && (paddr == 12'h018 || paddr == 12'h01c)
      |-> prdata == 32'h0 && !pslverr; endproperty
   a_tst: assert property (p_tst) else $error("test word not zero");
   property p_p45; pair_active_q[2] |-> chan_enable_q[4] == chan_enable_q[5]
      && chan_polarity_q[4] == chan_polarity_q[5]; endproperty
   a_p45: assert property (p_p45) else $error("pair 4/5 controls split");
   // One cycle of slack; the pin stage updates on the same edge as the pairing state
   property p_p01; pair_active_q[0] && $past(pair_active_q[0])
      |-> !modulator_output_port[0]; endproperty
   a_p01: assert property (p_p01) else $error("high byte pin driven");
   // A scale write reloads the counter, so the divide stage cannot toggle on that edge
   property p_sca; pready && pwrite && paddr == 12'h020 |-> ##2 $stable(scaled_clock_a);
   endproperty
   a_sca: assert property (p_sca) else $error("scale write did not reload");
endmodule // pwmps_chk
bind pwmps_top pwmps_chk u_pwmps_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .pair_active_q, .chan_enable_q, .chan_polarity_q,
   .modulator_output_port, .scaled_clock_a);

/* test/tb_pwmps_top.sv */
/* Self-checking bench for pwmps_top: registers, pairing, scaling, halts.
   Assumes the checker binds itself; APB master lives here. */
`timescale 1ns/1ns
module tb_pwmps_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, d;
   logic pready, pslverr, wait_mode = 0, freeze_mode = 0, scaled_clock_a, scaled_clock_b;
   logic [5:0] chan_wave = 0, chan_tick_q, chan_enable_q, chan_polarity_q, chan_align_q;
   logic [5:0] modulator_output_port;
   logic [2:0] pair_wave = 0, pair_active_q;
   logic [7:0] v;
   int mismatches = 0, compares = 0, n, s, pr;
   always #20 pclk = ~pclk;
   pwmps_top u_pwmps_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .wait_mode, .freeze_mode, .chan_wave, .pair_wave,
      .chan_tick_q, .chan_enable_q, .chan_polarity_q, .chan_align_q, .pair_active_q,
      .modulator_output_port, .scaled_clock_a, .scaled_clock_b);
   task automatic chk(input logic [31:0] g, e, input string m);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic conclude;
      if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Holds the request until pready; one idle edge keeps drivers single-assigned
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= x;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic x);
      apb(0, a, 0);
      chk(rd, e, "read");
      chk(err, x, "slverr");
   endtask
   task automatic per(input logic b, output int c);
      int r, k;
      logic o, t;
      r = 0;
      c = 0;
      o = 1;
      for (k = 0; k < 5000 && r < 2; k++) begin
         @(posedge pclk);
         t = b ? scaled_clock_b : scaled_clock_a;
         if (r == 1) c++;
         if (t && !o) r++;
         o = t;
      end
   endtask
   function automatic logic [5:0] pins(logic [2:0] j, logic [5:0] e, w, logic [2:0] p);
      pins = w & e;
      for (int q = 0; q < 3; q++)
         if (j[q]) begin
            pins[2*q] = 0;
            pins[2*q+1] = p[q] & e[2*q+1];
         end
   endfunction
   function automatic logic [5:0] effc(logic [2:0] j, logic [5:0] e);
      effc = e;
      for (int q = 0; q < 3; q++)
         if (j[q]) effc[2*q] = e[2*q+1];
   endfunction
   initial begin
      // Six scale periods of up to 2048 cycles dominate; 60000 cycles leave ample room
      #2400000;
      mismatches++;
      conclude;
   end
   initial begin
      void'($urandom(22));
      repeat (8) @(posedge pclk);
      chk(modulator_output_port, 0, "pins in reset");
      presetn <= 1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         v = $urandom;
         apb(1, 12'h014, v);
         rdc(12'h014, v & 8'h7c, 0);
         apb(1, 12'h018 + 4 * (i % 2), v);
         rdc(12'h018 + 4 * (i % 2), 0, 0);
      end
      rdc(12'h028, 0, 1);
      rdc(12'h015, 0, 1);
      for (int p = 0; p < 8; p++) begin
         d = $urandom & 32'h3f3f3f3f;
         // Pairing only changes while every channel is disabled
         apb(1, 12'h010, d & 32'h00ff_ffff);
         apb(1, 12'h014, p << 4);
         apb(1, 12'h010, d);
         chan_wave <= $urandom;
         pair_wave <= $urandom;
         repeat (4) @(posedge pclk);
         chk(pair_active_q, p, "pairing");
         chk(modulator_output_port, pins(p, d[29:24], chan_wave, pair_wave), "pins");
         chk(chan_polarity_q, effc(p, d[13:8]), "polarity");
         chk(chan_align_q, effc(p, d[21:16]), "align");
         chk(chan_enable_q, effc(p, d[29:24]), "enable");
         chk(chan_tick_q | effc(p, d[5:0]), 6'h3f, "ticks");
      end
      // Random scales with the zero case first for each clock
      for (int k = 0; k < 6; k++) begin
         s = k < 2 ? 0 : 1 + $urandom % 8;
         pr = $urandom % 3;
         apb(1, 12'h00c, {pr[2:0], 1'b0, pr[2:0]});
         apb(1, k[0] ? 12'h024 : 12'h020, s);
         per(k[0], n);
         chk(n, (s == 0 ? 512 : 2 * s) << pr, "scaled period");
      end
      apb(1, 12'h00c, 0);
      apb(1, 12'h020, 2);
      // Freeze, wait, then freeze left by the mode pin instead of the control bit
      for (int m = 0; m < 3; m++) begin
         apb(1, 12'h014, m == 1 ? 8'h08 : 8'h04);
         wait_mode <= (m == 1);
         freeze_mode <= (m != 1);
         repeat (6) @(posedge pclk);
         rdc(12'h014, m == 1 ? 8'h08 : 8'h04, 0);
         n = 0;
         v[0] = scaled_clock_a;
         repeat (40) begin
            @(posedge pclk);
            if (scaled_clock_a !== v[0]) n++;
         end
         chk(n, 0, "halted");
         if (m == 2) freeze_mode <= 0;
         else apb(1, 12'h014, 0);
         per(0, n);
         chk(n, 4, "resumed");
         wait_mode <= 0;
         freeze_mode <= 0;
      end
      conclude;
   end
endmodule // tb_pwmps_top
